//--- hw/smart_status_reporter.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "smart_regs.svh"

module smart_status_reporter (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // media and self-test events
    input wire logic oc_done,
    input wire logic oc_fatal,
    input wire logic oc_resume,
    input wire logic st_tick,
    input wire logic st_done,
    input wire logic [3:0] st_result,
    input wire logic host_reset,
    input wire logic threshold_exceeded,
    // power
    input wire logic spindle_stopped,
    input wire logic wake,
    output logic spin_down,
    output logic save_req,
    output logic standby
);

    smart_pkg::state_t s_r;
    smart_pkg::state_t s_nxt;
    logic [31:0] log_mem [0:(`LOG_SECT*`LOG_WORDS)-1];

    logic acc;
    logic setup;
    logic wr_cmd;
    logic mem_we;
    logic [7:0] op;
    logic [7:0] sub;
    logic [7:0] oc_byte;
    logic [7:0] st_byte;
    logic [7:0] csum;
    logic [15:0] smart_cap;

    assign acc = psel & penable & s_r.pready;
    assign setup = psel & penable & ~s_r.pready;
    assign wr_cmd = acc & pwrite & (paddr == `A_CMD);
    assign mem_we = acc & pwrite & (paddr == `A_LDATA) & (s_r.wr_left != 9'h000);
    assign op = pwdata[7:0];
    assign sub = pwdata[15:8];

    // ----------------------------------------
    // status bytes and checksum
    // ----------------------------------------
    function automatic logic [6:0] oc_code(input smart_pkg::oc_state_t st);
        unique case (st)
            smart_pkg::OC_IDLE: oc_code = `OC_NEVER;
            smart_pkg::OC_RUNNING: oc_code = `OC_NEVER;
            smart_pkg::OC_COMPLETE: oc_code = `OC_DONE;
            smart_pkg::OC_SUSPENDED: oc_code = `OC_SUSP;
            smart_pkg::OC_HOST_ABORT: oc_code = `OC_ABH;
            smart_pkg::OC_DEV_ABORT: oc_code = `OC_ABD;
            default: oc_code = `OC_NEVER;
        endcase
    endfunction : oc_code

    function automatic logic [8:0] words(input logic [7:0] c);
        words = (c >= 8'(`LOG_SECT)) ? 9'(`LOG_SECT * `LOG_WORDS) : 9'(c * `LOG_WORDS);
    endfunction : words

    assign oc_byte = {s_r.auto_en, oc_code(s_r.oc_st)};
    assign st_byte = {s_r.st_code, s_r.st_rem};
    assign smart_cap = {14'h0000, 1'b1, s_r.save_en};
    assign csum = 8'(8'h00 - (oc_byte + st_byte + s_r.total_time[7:0] + s_r.total_time[15:8]
                  + {3'h0, s_r.off_cap} + smart_cap[7:0] + smart_cap[15:8] + s_r.poll));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.spin_down = 1'b0;
        s_nxt.save_req = 1'b0;
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0;

        // collection events
        if (s_r.oc_st == smart_pkg::OC_RUNNING && oc_fatal)
            s_nxt.oc_st = smart_pkg::OC_DEV_ABORT;
        else if (s_r.oc_st == smart_pkg::OC_RUNNING && oc_done)
            s_nxt.oc_st = smart_pkg::OC_COMPLETE;
        else if (s_r.oc_st == smart_pkg::OC_SUSPENDED && oc_resume)
            s_nxt.oc_st = smart_pkg::OC_RUNNING;

        // self-test events
        if (s_r.st_code == `ST_RUN)
        begin
            if (host_reset)
            begin
                s_nxt.st_code = `ST_RESET;
                s_nxt.st_rem = 4'h0;
            end
            else if (st_done)
            begin
                // unknown result codes fold into fatal
                s_nxt.st_code = (st_result > `ST_LAST) ? `ST_FATAL : st_result;
                s_nxt.st_rem = 4'h0;
            end
            else if (st_tick && s_r.st_rem != 4'h0)
                s_nxt.st_rem = s_r.st_rem - 4'h1;
        end

        if (wake && s_r.standby)
        begin
            s_nxt.standby = 1'b0;
            s_nxt.save_req = s_r.save_en;
        end

        // apb read data
        if (setup && !pwrite)
        begin
            s_nxt.prdata = 32'h0000_0000;
            unique case (paddr)
                `A_CMD: s_nxt.prdata = {24'h00_0000, s_r.last_cmd};
                `A_STAT: s_nxt.prdata = {13'h0000, s_r.cmd_err, spindle_stopped, s_r.standby, st_byte, oc_byte};
                `A_CYL: s_nxt.prdata = {16'h0000, s_r.cyl_hi, s_r.cyl_lo};
                `A_TTIME: s_nxt.prdata = {16'h0000, s_r.total_time};
                `A_CAP: s_nxt.prdata = {8'h00, smart_cap, 3'h0, s_r.off_cap};
                `A_POLL: s_nxt.prdata = {24'h00_0000, s_r.poll};
                `A_LPTR: s_nxt.prdata = {6'h00, s_r.rd_left, s_r.wr_left, s_r.log_ptr};
                `A_LDATA: s_nxt.prdata = (s_r.rd_left != 9'h000) ? log_mem[s_r.log_ptr] : 32'h0000_0000;
                `A_CSUM: s_nxt.prdata = {24'h00_0000, csum};
                `A_CTRL: s_nxt.prdata = {31'h0000_0000, s_r.auto_en};
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        else if (setup)
        begin
            unique case (paddr)
                `A_CMD, `A_TTIME, `A_CAP, `A_POLL, `A_LDATA, `A_CTRL: s_nxt.pslverr = 1'b0;
                default: s_nxt.pslverr = 1'b1;
            endcase
        end

        // log transfers
        if (acc && !pwrite && paddr == `A_LDATA && s_r.rd_left != 9'h000)
        begin
            s_nxt.log_ptr = s_r.log_ptr + 8'h01;
            s_nxt.rd_left = s_r.rd_left - 9'h001;
        end
        if (mem_we)
        begin
            s_nxt.log_ptr = s_r.log_ptr + 8'h01;
            s_nxt.wr_left = s_r.wr_left - 9'h001;
        end

        // configuration writes
        if (acc && pwrite)
        begin
            unique case (paddr)
                `A_TTIME: s_nxt.total_time = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                `A_CAP:
                begin
                    s_nxt.off_cap = pwdata[`CAP_W-1:0];
                    s_nxt.save_en = pwdata[8];
                end
                `A_POLL: s_nxt.poll = pwdata[7:0];
                `A_CTRL: s_nxt.auto_en = pwdata[0];
                default: s_nxt.auto_en = s_r.auto_en;
            endcase
        end

        // commands
        if (wr_cmd)
        begin
            s_nxt.last_cmd = op;
            s_nxt.cmd_err = 1'b0;
            if (s_r.oc_st == smart_pkg::OC_RUNNING)
                s_nxt.oc_st = s_r.off_cap[`CAP_ABORT] ? smart_pkg::OC_HOST_ABORT
                                                     : smart_pkg::OC_SUSPENDED;
            unique case (op)
                `OP_OFFLINE:
                begin
                    if (sub == `SUB_COLLECT && s_r.off_cap[`CAP_IMM])
                        s_nxt.oc_st = smart_pkg::OC_RUNNING;
                    else if ((sub == `SUB_SHORT || sub == `SUB_EXT) && s_r.off_cap[`CAP_TEST]
                             && s_r.st_code != `ST_RUN)
                    begin
                        s_nxt.st_code = `ST_RUN;
                        s_nxt.st_rem = `ST_REM_START;
                    end
                    else if (sub == `SUB_ABORT && s_r.st_code == `ST_RUN)
                    begin
                        s_nxt.st_code = `ST_ABORT;
                        s_nxt.st_rem = 4'h0;
                    end
                    else
                        s_nxt.cmd_err = 1'b1;
                end
                `OP_RDLOG:
                begin
                    s_nxt.log_ptr = {sub[0], 7'h00};
                    s_nxt.rd_left = words(pwdata[23:16]);
                    s_nxt.wr_left = 9'h000;
                end
                `OP_WRLOG:
                begin
                    s_nxt.log_ptr = {sub[0], 7'h00};
                    s_nxt.wr_left = words(pwdata[23:16]);
                    s_nxt.rd_left = 9'h000;
                end
                `OP_RSTAT:
                begin
                    s_nxt.cyl_lo = threshold_exceeded ? `CYL_BAD_LO : `CYL_OK_LO;
                    s_nxt.cyl_hi = threshold_exceeded ? `CYL_BAD_HI : `CYL_OK_HI;
                end
                `OP_STBY:
                begin
                    // completion is immediate; the spindle follows on its own
                    s_nxt.standby = 1'b1;
                    s_nxt.spin_down = !spindle_stopped;
                    s_nxt.save_req = s_r.save_en && !s_r.standby;
                end
                default: s_nxt.cmd_err = 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.total_time <= `TTIME_RST;
            s_r.off_cap <= `OFF_CAP_RST;
            s_r.save_en <= `SAVE_RST;
            s_r.poll <= `POLL_RST;
        end
        else if (ce)
            s_r <= s_nxt;
    end

    always_ff @(posedge clock)
    begin
        if (ce && mem_we)
            log_mem[s_r.log_ptr] <= pwdata;
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign spin_down = s_r.spin_down;
    assign save_req = s_r.save_req;
    assign standby = s_r.standby;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    oc_code_legal_a: assert property (oc_byte[6:0] inside {`OC_NEVER, `OC_DONE, `OC_SUSP, `OC_ABH, `OC_ABD})
        else $error("reserved off-line status code");
    ttime_nonzero_a: assert property (s_r.total_time != 16'h0000)
        else $error("total time word is zero");
    st_code_legal_a: assert property (s_r.st_code <= `ST_LAST || s_r.st_code == `ST_RUN)
        else $error("reserved self-test status");
    st_rem_idle_a: assert property (s_r.st_rem <= `ST_REM_START && (s_r.st_code != `ST_RUN -> s_r.st_rem == 4'h0))
        else $error("remaining nibble out of range");
    st_start_a: assert property (ce && wr_cmd && op == `OP_OFFLINE && sub == `SUB_SHORT && s_r.off_cap[`CAP_TEST]
        && s_r.st_code != `ST_RUN |=> s_r.st_code == `ST_RUN && s_r.st_rem == `ST_REM_START)
        else $error("self-test start not shown");
    imm_unsup_a: assert property (ce && wr_cmd && op == `OP_OFFLINE && sub == `SUB_COLLECT && !s_r.off_cap[`CAP_IMM]
        |=> s_r.cmd_err && s_r.oc_st != smart_pkg::OC_RUNNING)
        else $error("collection started without capability");
    interrupt_mode_a: assert property (ce && wr_cmd && s_r.oc_st == smart_pkg::OC_RUNNING && op != `OP_OFFLINE
        |=> s_r.oc_st == ($past(s_r.off_cap[`CAP_ABORT]) ? smart_pkg::OC_HOST_ABORT : smart_pkg::OC_SUSPENDED))
        else $error("wrong abort or suspend");
    rstat_sig_a: assert property (ce && wr_cmd && op == `OP_RSTAT
        |=> {s_r.cyl_hi, s_r.cyl_lo} == ($past(threshold_exceeded) ? {`CYL_BAD_HI, `CYL_BAD_LO} : {`CYL_OK_HI, `CYL_OK_LO}))
        else $error("return status signature wrong");
    cap_read_a: assert property (ce && setup && !pwrite && paddr == `A_CAP
        |=> prdata[9] && prdata[7:5] == 3'h0 && prdata[23:10] == 14'h0000)
        else $error("capability read shows reserved bits");
    csum_zero_a: assert property (ce && setup && !pwrite && paddr == `A_CSUM
        |=> 8'(prdata[7:0] + $past(oc_byte) + $past(st_byte) + $past(s_r.total_time[7:0])
        + $past(s_r.total_time[15:8]) + {3'h0, $past(s_r.off_cap)} + $past(smart_cap[7:0])
        + $past(smart_cap[15:8]) + $past(s_r.poll)) == 8'h00)
        else $error("checksum does not sum to zero");
    stby_spin_a: assert property (ce && wr_cmd && op == `OP_STBY |=> standby && spin_down == !$past(spindle_stopped))
        else $error("standby spin-down wrong");
    stby_save_a: assert property (ce && wr_cmd && op == `OP_STBY && !standby |=> save_req == $past(s_r.save_en))
        else $error("standby save wrong");
    log_wr_a: assert property (ce && mem_we |=> s_r.log_ptr == 8'($past(s_r.log_ptr) + 8'h01))
        else $error("log pointer did not advance");

    st_done_c: cover property (s_r.st_code == `ST_RUN ##[1:50] s_r.st_code == `ST_OK);
    oc_susp_c: cover property (s_r.oc_st == smart_pkg::OC_SUSPENDED ##[1:50] s_r.oc_st == smart_pkg::OC_COMPLETE);
    stby_c: cover property (spin_down ##[1:50] wake);

endmodule : smart_status_reporter

//--- hw/smart_regs.svh
// Contract
// - off-line status reads 00h/80h never started, 02h/82h completed without error
// - off-line status 04h/84h suspended, 05h/85h host abort, 06h/86h device fatal abort
// - total collection time word is always nonzero, 0001h to FFFFh seconds
// - self-test low nibble gives remaining tenths, 9 down to 0
// - self-test high nibble 0 success or never, 1 host abort, 2 reset interrupted
// - failure codes 3 fatal, 4 unknown element, 5 electrical, 6 servo, 7 read, 8 handling
// - running self-test shows 15 in high nibble; 9 to 14 never reported
// - off-line capability bit 0 set exactly when immediate off-line execution supported
// - capability bit 2 set: new command aborts collection; clear: suspend then resume
// - capability bit 3 read scanning, bit 4 self-tests; bits 7 to 5 reserved
// - all off-line capability bits zero means no off-line collection at all
// - smart capability bit 0 set: save data entering standby and on wake
// - smart capability bit 1 always reads one; bits 15 to 2 reserved
// - checksum byte is two's complement of byte sum of preceding 511 bytes
// - return status without threshold exceeded loads 4Fh low and C2h high
// - return status with threshold exceeded loads F4h low and 2Ch high
// - log read transfers the addressed log sectors to the host
// - log write stores the requested count of 512-byte sectors at the address; counts above 2 store only 2 sectors
// - standby command enters standby; completion may precede the transition
// - standby with spindle already stopped skips the spin-down sequence
`ifndef SMART_REGS_SVH
`define SMART_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define A_CMD 8'h00
`define A_STAT 8'h04
`define A_CYL 8'h08
`define A_TTIME 8'h0C
`define A_CAP 8'h10
`define A_POLL 8'h14
`define A_LPTR 8'h18
`define A_LDATA 8'h1C
`define A_CSUM 8'h20
`define A_CTRL 8'h24

// ----------------------------------------
// command and subcommand codes
// ----------------------------------------
`define OP_OFFLINE 8'hD4
`define OP_RDLOG 8'hD5
`define OP_WRLOG 8'hD6
`define OP_RSTAT 8'hDA
`define OP_STBY 8'hE2
`define SUB_COLLECT 8'h00
`define SUB_SHORT 8'h01
`define SUB_EXT 8'h02
`define SUB_ABORT 8'h7F

// ----------------------------------------
// status encodings
// ----------------------------------------
`define OC_NEVER 7'h00
`define OC_DONE 7'h02
`define OC_SUSP 7'h04
`define OC_ABH 7'h05
`define OC_ABD 7'h06
`define ST_OK 4'h0
`define ST_ABORT 4'h1
`define ST_RESET 4'h2
`define ST_FATAL 4'h3
`define ST_LAST 4'h8
`define ST_RUN 4'hF
`define ST_REM_START 4'h9
`define CYL_OK_LO 8'h4F
`define CYL_OK_HI 8'hC2
`define CYL_BAD_LO 8'hF4
`define CYL_BAD_HI 8'h2C

// ----------------------------------------
// capability fields and reset values
// ----------------------------------------
`define CAP_IMM 0
`define CAP_ABORT 2
`define CAP_TEST 4
`define CAP_W 5
`define OFF_CAP_RST 5'h1D
`define TTIME_RST 16'h0078
`define POLL_RST 8'h02
`define SAVE_RST 1'h1
`define LOG_WORDS 128
`define LOG_SECT 2
`define LOG_AW 8

`endif

//--- hw/smart_pkg.sv
package smart_pkg;

    // gray along never -> run -> done
    typedef enum logic [2:0] {
        OC_IDLE = 3'h0,
        OC_RUNNING = 3'h1,
        OC_COMPLETE = 3'h3,
        OC_SUSPENDED = 3'h2,
        OC_HOST_ABORT = 3'h6,
        OC_DEV_ABORT = 3'h7
    } oc_state_t;

    typedef struct packed {
        oc_state_t oc_st;
        logic [3:0] st_code;
        logic [3:0] st_rem;
        logic [15:0] total_time;
        logic [4:0] off_cap;
        logic save_en;
        logic [7:0] poll;
        logic auto_en;
        logic standby;
        logic cmd_err;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] last_cmd;
        logic [7:0] log_ptr;
        logic [8:0] wr_left;
        logic [8:0] rd_left;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic spin_down;
        logic save_req;
    } state_t;

endpackage : smart_pkg

//--- testbench/host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// host controller side of the register bus
// ----------------------------------------
module host_model #(
    parameter int CYC_PER_MIN = 8
) (
    // clock
    input wire logic clock,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // one transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask : apb

    // first status poll only after the recommended interval
    task automatic wait_poll(input logic [7:0] minutes);
        repeat (int'(minutes) * CYC_PER_MIN) @(posedge clock);
    endtask : wait_poll
endmodule : host_model

//--- testbench/smart_status_reporter_bench.sv
`timescale 1ns/1ps
`include "smart_regs.svh"

module smart_status_reporter_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, v;
    logic [7:0] ev_r = 8'h00;
    logic [3:0] st_result = 4'h0;
    logic threshold_exceeded = 1'b0;
    logic spindle_stopped = 1'b0;
    logic spin_down, save_req, standby;
    logic [31:0] seed = 32'h0000B4C2;
    logic [31:0] logmem [0:127];
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_spin = 0;
    int n_save = 0;
    int i;

    always #2.5 clock = ~clock;

    smart_status_reporter smart_status_reporter_inst (
        .clock(clock), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .oc_done(ev_r[0]), .oc_fatal(ev_r[1]), .oc_resume(ev_r[2]), .st_tick(ev_r[3]),
        .st_done(ev_r[4]), .st_result(st_result), .host_reset(ev_r[5]),
        .threshold_exceeded(threshold_exceeded), .spindle_stopped(spindle_stopped), .wake(ev_r[6]),
        .spin_down(spin_down), .save_req(save_req), .standby(standby)
    );

    host_model host_model_inst (
        .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    task automatic final_report();
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // ----------------------------------------
    // pulse counters and hang guard
    // ----------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        if (spin_down === 1'b1)
            n_spin++;
        if (save_req === 1'b1)
            n_save++;
        if (cycles == 30000)
        begin
            fails++;
            final_report();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [3:0] st_exp(input logic [3:0] r);
        return (r > 4'h8) ? 4'h3 : r;
    endfunction : st_exp

    task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
        n_checks++;
        if (got !== expv)
        begin
            $display("BAD %s expected %h seen %h", name, expv, got);
            fails++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_model_inst.apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] expv);
        host_model_inst.apb(1'b0, a, 32'h00000000, q, e);
        chk(name, expv & m, q & m);
        chk("pslverr", 32'h00000000, {31'h00000000, e});
    endtask : rd

    task automatic ev(input int b);
        @(posedge clock);
        ev_r <= 8'h01 << b;
        @(posedge clock);
        ev_r <= 8'h00;
    endtask : ev

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd("stat", `A_STAT, 32'hFFFFFFFF, 32'h00000000);
        rd("ttime", `A_TTIME, 32'h0000FFFF, 32'h00000078);
        rd("cap", `A_CAP, 32'hFFFFFFFF, 32'h0000031D);
        rd("poll", `A_POLL, 32'h000000FF, 32'h00000002);
        rd("cyl", `A_CYL, 32'h0000FFFF, 32'h00000000);
        host_model_inst.apb(1'b0, 8'h28, 32'h00000000, q, e);
        chk("unmapped pslverr", 32'h00000001, {31'h00000000, e});
        wr(`A_STAT, rnd());
        rd("stat ro", `A_STAT, 32'hFFFFFFFF, 32'h00000000);
        v = rnd();
        v = {16'h0000, v[15:0]} | 32'h00000001;
        wr(`A_TTIME, v);
        rd("ttime", `A_TTIME, 32'h0000FFFF, v);
        wr(`A_TTIME, 32'h00000000);
        rd("ttime zero", `A_TTIME, 32'h0000FFFF, 32'h00000001);
        v = rnd();
        v = {24'h000000, v[7:0]};
        wr(`A_POLL, v);
        rd("poll", `A_POLL, 32'h000000FF, v);
        wr(`A_POLL, 32'h00000002);
        // collection status codes
        wr(`A_CTRL, 32'h00000001);
        wr(`A_CMD, 32'h000000D4);
        rd("oc run", `A_STAT, 32'h000000FF, 32'h00000080);
        ev(0);
        rd("oc done", `A_STAT, 32'h000000FF, 32'h00000082);
        wr(`A_CMD, 32'h000000D4);
        wr(`A_CMD, 32'h000000DA);
        rd("oc host abort", `A_STAT, 32'h000000FF, 32'h00000085);
        wr(`A_CAP, 32'h00000119);
        wr(`A_CMD, 32'h000000D4);
        wr(`A_CMD, 32'h000000DA);
        rd("oc suspend", `A_STAT, 32'h000000FF, 32'h00000084);
        ev(2);
        rd("oc resume", `A_STAT, 32'h000000FF, 32'h00000080);
        ev(1);
        rd("oc fatal", `A_STAT, 32'h000000FF, 32'h00000086);
        wr(`A_CTRL, 32'h00000000);
        rd("oc fatal", `A_STAT, 32'h000000FF, 32'h00000006);
        wr(`A_CAP, 32'h00000100);
        wr(`A_CMD, 32'h000000D4);
        rd("no collection", `A_STAT, 32'h000400FF, 32'h00040006);
        wr(`A_CAP, 32'h0000011D);
        // return status signature
        for (i = 0; i < 2; i++)
        begin
            @(posedge clock);
            threshold_exceeded <= i[0];
            wr(`A_CMD, 32'h000000DA);
            rd("cyl", `A_CYL, 32'h0000FFFF, i[0] ? 32'h00002CF4 : 32'h0000C24F);
        end
        // self-test status byte
        wr(`A_CMD, 32'h000001D4);
        host_model_inst.wait_poll(8'h02);
        rd("test run", `A_STAT, 32'h0000FF00, 32'h0000F900);
        repeat (3) ev(3);
        rd("test rem", `A_STAT, 32'h0000FF00, 32'h0000F600);
        for (i = 0; i < 16; i++)
        begin
            @(posedge clock);
            st_result <= i[3:0];
            ev(4);
            rd("test result", `A_STAT, 32'h0000FF00, {16'h0000, st_exp(i[3:0]), 12'h000});
            wr(`A_CMD, i[0] ? 32'h000001D4 : 32'h000002D4);
            rd("test run", `A_STAT, 32'h0000FF00, 32'h0000F900);
        end
        wr(`A_CMD, 32'h00007FD4);
        rd("test abort", `A_STAT, 32'h0000F000, 32'h00001000);
        wr(`A_CMD, 32'h000001D4);
        ev(5);
        rd("test reset", `A_STAT, 32'h0000F000, 32'h00002000);
        // log sectors
        wr(`A_CMD, 32'h000101D6);
        rd("lptr", `A_LPTR, 32'h0001FF00, 32'h00008000);
        for (i = 0; i < 128; i++)
        begin
            logmem[i] = rnd();
            wr(`A_LDATA, logmem[i]);
        end
        wr(`A_LDATA, rnd());
        wr(`A_CMD, 32'h000101D5);
        for (i = 0; i < 128; i++)
            rd("ldata", `A_LDATA, 32'hFFFFFFFF, logmem[i]);
        rd("ldata idle", `A_LDATA, 32'hFFFFFFFF, 32'h00000000);
        // standby and data saving
        wr(`A_CMD, 32'h000000E2);
        idle(2);
        chk("standby", 32'h00000001, {31'h00000000, standby});
        chk("spin_down count", 32'h00000001, 32'(n_spin));
        chk("save_req count", 32'h00000001, 32'(n_save));
        ev(6);
        idle(2);
        chk("standby", 32'h00000000, {31'h00000000, standby});
        chk("save_req count", 32'h00000002, 32'(n_save));
        @(posedge clock);
        spindle_stopped <= 1'b1;
        wr(`A_CMD, 32'h000000E2);
        idle(2);
        chk("spin_down count", 32'h00000001, 32'(n_spin));
        chk("save_req count", 32'h00000003, 32'(n_save));
        rd("stat power", `A_STAT, 32'h00030000, 32'h00030000);
        ev(6);
        wr(`A_CAP, 32'h0000001D);
        rd("cap", `A_CAP, 32'hFFFFFFFF, 32'h0000021D);
        wr(`A_CMD, 32'h000000E2);
        idle(2);
        chk("save_req count", 32'h00000004, 32'(n_save));
        rd("csum", `A_CSUM, 32'h000000FF, 32'h000000B8);
        final_report();
    end
endmodule : smart_status_reporter_bench
